// File: hw/nfcc_top.sv
// apb-driven controller that issues command sequences to a parallel nor flash
// assumes apb master on i_sys_clk and flash pins synchronous to i_sys_clk
//
// Contract
// (R1) two-cycle commands: setup write then confirm write back to back
// (R2) config register load: 0060h then 0004h, value on address both times
// (R3) read modes: FFh array, 70h status, 90h identifier, 98h query
// (R4) program: 40h or 10h then data; buffered: E8h then D0h
// (R5) erase: 20h then D0h in block; suspend B0h; resume D0h
// (R6) lock 60h/01h, unlock 60h/D0h at block; otp C0h then offset and data
// (R7) clear status: single write of 0050h, any address
// (R8) status read returns byte on low lanes, upper byte zero
// (R9) device sets status bits; error bits stay until clear status
// (R10) status byte is 80h after power-up or reset
// (R11) no page-mode reads in status-read mode
// (R12) status latched on output enable fall or selecting chip enable edge
// (R13) host returns output enable high between status reads
// (R14) bit 7 is 0 busy, 1 ready; low bits valid only when ready
// (R15) bit 6 erase suspended, bit 2 program suspended
// (R16) bits 5:4: success, program, erase, sequence error
// (R17) bit 3 set on programming voltage fault, operation aborted
// (R18) bit 1 set when program or erase targets a locked block
// (R19) clear status also selects status-read mode
// (R20) device reset clears status like clear status
// (R21) sequence error in erase suspend sets bits 4 and 5, masks erase error
// (R22) host clears status before resuming a suspended erase
// (R23) status reads and clear status work at any programming voltage
// (R24) device latches command on write enable rise or deselecting edge
// (R25) starting program or erase switches read mode to status
// (R26) bad confirm aborts, sets bits 4 and 5, status-read mode
`timescale 1ns/1ns
module nfcc_top
  import nfcc_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // flash pins
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  output logic             o_reset_powerdown_n,
  output logic [23:0]      o_addr,
  output logic [15:0]      o_dq_out,
  output logic             o_dq_oe,
  input  wire logic [15:0] i_dq_in
);
  `include "nfcc_defines.svh"

  // ======================================================================
  // register decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // two-word sequence table: setup code, confirm code, flag set when a confirm write follows
  function automatic logic [32:0] seq_of(input nfcc_op_e op, input logic [15:0] wdat);
    case (op)
      NFCC_OP_READ_ARRAY: seq_of = {`NFCC_CMD_READ_ARRAY, 16'h0000, 1'b0};  // see (R3)
      NFCC_OP_READ_STATUS: seq_of = {`NFCC_CMD_READ_STATUS, 16'h0000, 1'b0}; // see (R3)
      NFCC_OP_READ_ID:    seq_of = {`NFCC_CMD_READ_ID, 16'h0000, 1'b0};     // see (R3)
      NFCC_OP_CFI:        seq_of = {`NFCC_CMD_CFI, 16'h0000, 1'b0};         // see (R3)
      NFCC_OP_PROG:       seq_of = {`NFCC_CMD_PROG_W, wdat, 1'b1};          // see (R4)
      NFCC_OP_BUF_PROG:   seq_of = {`NFCC_CMD_BUF_PROG, `NFCC_CMD_CONFIRM, 1'b1}; // see (R4)
      NFCC_OP_ERASE:      seq_of = {`NFCC_CMD_ERASE, `NFCC_CMD_CONFIRM, 1'b1}; // see (R5)
      NFCC_OP_SUSPEND:    seq_of = {`NFCC_CMD_SUSPEND, 16'h0000, 1'b0};     // see (R5)
      NFCC_OP_RESUME:     seq_of = {`NFCC_CMD_CLR_STATUS, `NFCC_CMD_CONFIRM, 1'b1}; // see (R22)
      NFCC_OP_LOCK:       seq_of = {`NFCC_CMD_LOCK_SETUP, `NFCC_CMD_LOCK_CONF, 1'b1}; // see (R6)
      NFCC_OP_UNLOCK:     seq_of = {`NFCC_CMD_LOCK_SETUP, `NFCC_CMD_CONFIRM, 1'b1}; // see (R6)
      NFCC_OP_OTP:        seq_of = {`NFCC_CMD_OTP_PROG, wdat, 1'b1};        // see (R6)
      NFCC_OP_ECR:        seq_of = {`NFCC_CMD_LOCK_SETUP, `NFCC_CMD_ECR_CONF, 1'b1}; // see (R2)
      NFCC_OP_CLR_STATUS: seq_of = {`NFCC_CMD_CLR_STATUS, 16'h0000, 1'b0};  // see (R7)
      default:            seq_of = {16'h0000, 16'h0000, 1'b0};
    endcase
  endfunction

  // ======================================================================
  // software registers
  logic [3:0]  op_code, next_op_code;
  logic [23:0] addr_reg, next_addr_reg;
  logic [15:0] wdata_reg, next_wdata_reg;
  logic [15:0] rdata_reg, next_rdata_reg;
  logic [7:0]  devsr, next_devsr;
  logic        in_status_mode, next_in_status_mode;

  logic apb_wr;
  logic apb_rd;
  logic go;
  logic busy;
  logic rst_go;

  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_rd = i_psel && i_penable && !i_pwrite;
  assign go     = apb_wr && hit(i_paddr, `NFCC_CTRL_OFS) && i_pwdata[`NFCC_CTRL_GO_BIT] && !busy;
  assign rst_go = apb_wr && hit(i_paddr, `NFCC_CTRL_OFS) && i_pwdata[`NFCC_CTRL_RST_BIT]
                  && !busy;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !(hit(i_paddr, `NFCC_CTRL_OFS)
                     || hit(i_paddr, `NFCC_ADDR_OFS) || hit(i_paddr, `NFCC_WDATA_OFS)
                     || hit(i_paddr, `NFCC_STAT_OFS) || hit(i_paddr, `NFCC_RDATA_OFS)
                     || hit(i_paddr, `NFCC_DEVSR_OFS));

  // ======================================================================
  // sequencer
  typedef enum logic [2:0] {
    NFCC_SQ_IDLE, NFCC_SQ_SETUP, NFCC_SQ_CONFIRM, NFCC_SQ_READ, NFCC_SQ_RESET
  } nfcc_sq_e;
  nfcc_sq_e   sq, next_sq;
  logic [3:0] rcnt, next_rcnt;
  logic [32:0] seq;

  nfcc_cyc_if cyc ();

  assign busy = (sq != NFCC_SQ_IDLE);
  assign seq  = seq_of(nfcc_op_e'(op_code), wdata_reg);

  always_comb begin
    next_sq             = sq;
    next_rcnt           = rcnt;
    next_op_code        = op_code;
    next_addr_reg       = addr_reg;
    next_wdata_reg      = wdata_reg;
    next_rdata_reg      = rdata_reg;
    next_devsr          = devsr;
    next_in_status_mode = in_status_mode;
    cyc.req   = 1'b0;
    cyc.wr    = 1'b1;
    cyc.addr  = addr_reg;
    cyc.wdata = seq[32:17];
    if (apb_wr && !busy) begin
      if (hit(i_paddr, `NFCC_ADDR_OFS)) begin
        next_addr_reg = i_pwdata[23:0];
      end
      if (hit(i_paddr, `NFCC_WDATA_OFS)) begin
        next_wdata_reg = i_pwdata[15:0];
      end
      if (hit(i_paddr, `NFCC_CTRL_OFS)) begin
        next_op_code = i_pwdata[`NFCC_CTRL_CODE_LSB +: `NFCC_CTRL_CODE_W];
      end
    end
    case (sq)
      NFCC_SQ_IDLE: begin
        if (rst_go) begin
          next_sq   = NFCC_SQ_RESET;
          next_rcnt = 4'(`NFCC_T_RST_CYC);
        end else if (go) begin
          if (nfcc_op_e'(i_pwdata[3:0]) == NFCC_OP_READ) begin
            next_sq = NFCC_SQ_READ;
          end else begin
            next_sq = NFCC_SQ_SETUP;
          end
        end
      end
      NFCC_SQ_SETUP: begin
        cyc.req = 1'b1;
        if (cyc.done) begin
          // single-cycle commands end here, two-cycle go straight to confirm, see (R1)
          next_sq = seq[0] ? NFCC_SQ_CONFIRM : NFCC_SQ_IDLE;
          case (nfcc_op_e'(op_code))
            NFCC_OP_READ_STATUS, NFCC_OP_CLR_STATUS: next_in_status_mode = 1'b1; // see (R19)
            NFCC_OP_READ_ARRAY, NFCC_OP_READ_ID, NFCC_OP_CFI: next_in_status_mode = 1'b0;
            default: ;
          endcase
        end
      end
      NFCC_SQ_CONFIRM: begin
        cyc.req   = 1'b1;
        cyc.wdata = seq[16:1];
        if (cyc.done) begin
          next_sq = NFCC_SQ_IDLE;
          if (nfcc_op_e'(op_code) != NFCC_OP_ECR) begin
            next_in_status_mode = 1'b1; // see (R25)
          end else begin
            next_in_status_mode = 1'b0;
          end
        end
      end
      NFCC_SQ_READ: begin
        cyc.req = 1'b1;
        cyc.wr  = 1'b0;
        if (cyc.done) begin
          next_sq = NFCC_SQ_IDLE;
          // status byte on low lanes, upper byte zero in status mode, see (R8)
          next_rdata_reg = in_status_mode ? {8'h00, cyc.rdata[7:0]} : cyc.rdata;
          if (in_status_mode) begin
            // low bits only meaningful when ready, see (R14)
            next_devsr = cyc.rdata[`NFCC_SR_READY_BIT] ? cyc.rdata[7:0] : 8'h00;
          end
        end
      end
      NFCC_SQ_RESET: begin
        if (rcnt == 4'h1) begin
          next_sq             = NFCC_SQ_IDLE;
          next_devsr          = `NFCC_SR_RESET; // see (R20)
          next_in_status_mode = 1'b0;
        end else begin
          next_rcnt = rcnt - 4'h1;
        end
      end
      default: next_sq = NFCC_SQ_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sq             <= NFCC_SQ_IDLE;
      rcnt           <= 4'h0;
      op_code        <= 4'h0;
      addr_reg       <= 24'h000000;
      wdata_reg      <= 16'h0000;
      rdata_reg      <= 16'h0000;
      devsr          <= `NFCC_SR_RESET; // see (R10)
      in_status_mode <= 1'b0;
    end else begin
      sq             <= next_sq;
      rcnt           <= next_rcnt;
      op_code        <= next_op_code;
      addr_reg       <= next_addr_reg;
      wdata_reg      <= next_wdata_reg;
      rdata_reg      <= next_rdata_reg;
      devsr          <= next_devsr;
      in_status_mode <= next_in_status_mode;
    end
  end

  assign o_reset_powerdown_n = (sq != NFCC_SQ_RESET);

  // ======================================================================
  // apb read data
  always_comb begin
    o_prdata = 32'h00000000;
    if (apb_rd) begin
      if (hit(i_paddr, `NFCC_CTRL_OFS)) begin
        o_prdata = {28'h0000000, op_code};
      end else if (hit(i_paddr, `NFCC_ADDR_OFS)) begin
        o_prdata = {8'h00, addr_reg};
      end else if (hit(i_paddr, `NFCC_WDATA_OFS)) begin
        o_prdata = {16'h0000, wdata_reg};
      end else if (hit(i_paddr, `NFCC_STAT_OFS)) begin
        o_prdata = {30'h00000000, in_status_mode, busy};
      end else if (hit(i_paddr, `NFCC_RDATA_OFS)) begin
        o_prdata = {16'h0000, rdata_reg};
      end else if (hit(i_paddr, `NFCC_DEVSR_OFS)) begin
        o_prdata = {24'h000000, devsr};
      end
    end
  end

  // ======================================================================
  // bus cycle engine
  nfcc_bus_cycle u_cycle (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .cyc       (cyc),
    .o_ce_n    (o_ce_n),
    .o_oe_n    (o_oe_n),
    .o_we_n    (o_we_n),
    .o_addr    (o_addr),
    .o_dq_out  (o_dq_out),
    .o_dq_oe   (o_dq_oe),
    .i_dq_in   (i_dq_in)
  );

  // ======================================================================
  // checks
  property p_confirm_follows;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (sq == NFCC_SQ_SETUP && cyc.done && seq[0]) |=> (sq == NFCC_SQ_CONFIRM);
  endproperty
  a_confirm_follows: assert property (p_confirm_follows) else $error("no confirm"); // see (R1)

  property p_single;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (sq == NFCC_SQ_SETUP && cyc.done && !seq[0]) |=> (sq == NFCC_SQ_IDLE);
  endproperty
  a_single: assert property (p_single) else $error("single cycle ran on"); // see (R7)

  property p_clr_code;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (sq == NFCC_SQ_SETUP && nfcc_op_e'(op_code) == NFCC_OP_CLR_STATUS && !o_we_n)
        |-> (o_dq_out == 16'h0050);
  endproperty
  a_clr_code: assert property (p_clr_code) else $error("clear code wrong"); // see (R7)

  property p_erase_conf;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (sq == NFCC_SQ_CONFIRM && nfcc_op_e'(op_code) == NFCC_OP_ERASE && !o_we_n)
        |-> (o_dq_out == 16'h00D0);
  endproperty
  a_erase_conf: assert property (p_erase_conf) else $error("erase confirm wrong"); // see (R5)

  property p_ecr_addr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (nfcc_op_e'(op_code) == NFCC_OP_ECR && !o_we_n) |-> (o_addr == addr_reg);
  endproperty
  a_ecr_addr: assert property (p_ecr_addr) else $error("config value not on address"); // see (R2)

  property p_status_mode;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (sq == NFCC_SQ_CONFIRM && cyc.done && nfcc_op_e'(op_code) == NFCC_OP_ERASE)
        |=> in_status_mode;
  endproperty
  a_status_mode: assert property (p_status_mode) else $error("not in status mode"); // see (R25)

  property p_rst_len;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $fell(o_reset_powerdown_n) |-> !o_reset_powerdown_n [*5] ##1 o_reset_powerdown_n;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong"); // see (R20)

  property p_rst_sr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_reset_powerdown_n) |-> (devsr == 8'h80) && !in_status_mode;
  endproperty
  a_rst_sr: assert property (p_rst_sr) else $error("status not 80h after reset"); // see (R10)
endmodule

// File: hw/nfcc_defines.svh
// constants of the flash command controller: register offsets, fields, codes, timing
// assumes inclusion by bare name from the package and modules
`ifndef NFCC_DEFINES_SVH
`define NFCC_DEFINES_SVH

// ======================================================================
// apb register offsets
`define NFCC_CTRL_OFS      12'h000
`define NFCC_ADDR_OFS      12'h004
`define NFCC_WDATA_OFS     12'h008
`define NFCC_STAT_OFS      12'h00C
`define NFCC_RDATA_OFS     12'h010
`define NFCC_DEVSR_OFS     12'h014

// ======================================================================
// ctrl fields
`define NFCC_CTRL_CODE_LSB 0
`define NFCC_CTRL_CODE_W   4
`define NFCC_CTRL_GO_BIT   8
`define NFCC_CTRL_RST_BIT  9

// ======================================================================
// command codes
`define NFCC_CMD_READ_ARRAY  16'h00FF
`define NFCC_CMD_READ_STATUS 16'h0070
`define NFCC_CMD_READ_ID     16'h0090
`define NFCC_CMD_CFI         16'h0098
`define NFCC_CMD_PROG_W      16'h0040
`define NFCC_CMD_PROG_B      16'h0010
`define NFCC_CMD_BUF_PROG    16'h00E8
`define NFCC_CMD_CONFIRM     16'h00D0
`define NFCC_CMD_ERASE       16'h0020
`define NFCC_CMD_SUSPEND     16'h00B0
`define NFCC_CMD_LOCK_SETUP  16'h0060
`define NFCC_CMD_LOCK_CONF   16'h0001
`define NFCC_CMD_ECR_CONF    16'h0004
`define NFCC_CMD_OTP_PROG    16'h00C0
`define NFCC_CMD_CLR_STATUS  16'h0050

// ======================================================================
// device status byte
`define NFCC_SR_RESET        8'h80
`define NFCC_SR_READY_BIT    7

// ======================================================================
// bus timing, in ns, and derived cycles at 40 ns
`define NFCC_CLK_NS          40
`define NFCC_T_PULSE_NS      80
`define NFCC_T_PULSE_CYC     ((`NFCC_T_PULSE_NS + `NFCC_CLK_NS - 1) / `NFCC_CLK_NS)
`define NFCC_T_RST_NS        200
`define NFCC_T_RST_CYC       ((`NFCC_T_RST_NS + `NFCC_CLK_NS - 1) / `NFCC_CLK_NS)

`endif

// File: hw/nfcc_pkg.sv
// types of the flash command controller
// assumes nfcc_defines.svh on the include path
package nfcc_pkg;
  `include "nfcc_defines.svh"

  // ======================================================================
  // software operations
  typedef enum logic [3:0] {
    NFCC_OP_READ_ARRAY, NFCC_OP_READ_STATUS, NFCC_OP_READ_ID, NFCC_OP_CFI,
    NFCC_OP_PROG, NFCC_OP_BUF_PROG, NFCC_OP_ERASE, NFCC_OP_SUSPEND,
    NFCC_OP_RESUME, NFCC_OP_LOCK, NFCC_OP_UNLOCK, NFCC_OP_OTP,
    NFCC_OP_ECR, NFCC_OP_CLR_STATUS, NFCC_OP_READ
  } nfcc_op_e;

  typedef logic [15:0] nfcc_word_t;
endpackage

// File: hw/nfcc_cyc_if.sv
// request and answer lines between sequencer and bus cycle engine
// assumes one clock domain
`timescale 1ns/1ns
interface nfcc_cyc_if;
  logic        req;
  logic        wr;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// File: hw/nfcc_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
// assumes flash pins synchronous to i_sys_clk
`timescale 1ns/1ns
module nfcc_bus_cycle
  import nfcc_pkg::*;
(
  // clock and reset
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst_n,
  // cycle request
  nfcc_cyc_if.eng    cyc,
  // flash pins
  output logic       o_ce_n,
  output logic       o_oe_n,
  output logic       o_we_n,
  output logic [23:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic       o_dq_oe,
  input  wire logic [15:0] i_dq_in
);
  `include "nfcc_defines.svh"

  // ======================================================================
  // cycle state
  typedef enum logic [1:0] {NFCC_BC_IDLE, NFCC_BC_ACT, NFCC_BC_REC} nfcc_bc_e;
  nfcc_bc_e   st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [15:0] rd, next_rd;
  logic       wr, next_wr;
  logic [23:0] ad, next_ad;
  logic [15:0] wd, next_wd;

  always_comb begin
    next_st  = st;
    next_cnt = cnt;
    next_rd  = rd;
    next_wr  = wr;
    next_ad  = ad;
    next_wd  = wd;
    case (st)
      NFCC_BC_IDLE: begin
        if (cyc.req) begin
          next_st  = NFCC_BC_ACT;
          next_cnt = 4'(`NFCC_T_PULSE_CYC);
          next_wr  = cyc.wr;
          next_ad  = cyc.addr;
          next_wd  = cyc.wdata;
        end
      end
      NFCC_BC_ACT: begin
        if (cnt == 4'h1) begin
          // strobes rise here: device latches write on we rising, see (R24)
          next_st = NFCC_BC_REC;
          if (!wr) begin
            next_rd = i_dq_in;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      NFCC_BC_REC: begin
        // ce and oe return high between cycles so status latch refreshes, see (R13)
        next_st = NFCC_BC_IDLE;
      end
      default: next_st = NFCC_BC_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st  <= NFCC_BC_IDLE;
      cnt <= 4'h0;
      rd  <= 16'h0000;
      wr  <= 1'b0;
      ad  <= 24'h000000;
      wd  <= 16'h0000;
    end else begin
      st  <= next_st;
      cnt <= next_cnt;
      rd  <= next_rd;
      wr  <= next_wr;
      ad  <= next_ad;
      wd  <= next_wd;
    end
  end

  assign o_ce_n    = (st != NFCC_BC_ACT);
  assign o_oe_n    = !(st == NFCC_BC_ACT && !wr);
  assign o_we_n    = !(st == NFCC_BC_ACT && wr);
  assign o_addr    = ad;
  assign o_dq_out  = wd;
  assign o_dq_oe   = (st == NFCC_BC_ACT) && wr;
  assign cyc.done  = (st == NFCC_BC_REC);
  assign cyc.rdata = rd;

  // ======================================================================
  // checks
  property p_recover;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_ce_n) |-> o_ce_n && o_oe_n && o_we_n;
  endproperty
  a_recover: assert property (p_recover) else $error("strobes not high after cycle"); // see (R13)

  property p_pulse;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $fell(o_ce_n) |-> !o_ce_n [*2] ##1 o_ce_n;
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe pulse width wrong"); // see (R24)
endmodule

// File: tb/nfcc_flash_model.sv
// flash device model: command decoder, read modes and status byte
// assumes strobes come from the controller; the model has no clock
`timescale 1ns/1ns
module nfcc_flash_model (
  // flash pins
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_rpd_n,
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_dq,
  // answer speed
  input  wire logic        i_slow,
  output logic [15:0]      o_dq
);
  logic [7:0]  sr = 8'h80;
  logic [7:0]  lat = 8'h80;
  logic [7:0]  pnd = 8'h00;
  logic [7:0]  er;
  logic [15:0] rv;
  logic [15:0] lst = 16'h0;
  int          md = 0;
  int          bsy = 0;
  int          b;
  bit          lk [int];
  logic [7:0]  lop = 8'h00;
  bit          wa = 1'b0;
  bit          vok = 1'b1;
  // ======================================================================
  // command write
  always @(i_we_n or i_ce_n) if (!i_we_n && !i_ce_n) wa = 1'b1;
  always @(posedge i_we_n or posedge i_ce_n) begin
    b = int'(i_addr[23:17]);
    er = (pnd == 8'h20) ? 8'h22 : 8'h12;
    if (wa && i_rpd_n) begin
      wa = 1'b0;
      if (pnd == 8'h00) begin
        case (i_dq[7:0])
          8'hFF: md = 0;
          8'h70: md = 1;
          8'h90: md = 2;
          8'h98: md = 3;
          8'h50: begin
            sr = 8'h80;
            md = 1;
          end
          8'hB0: begin
            if (lop == 8'h20) sr[6] = 1'b1;
            else sr[2] = 1'b1;
          end
          8'hD0: sr = sr & 8'hBB;
          default: pnd = i_dq[7:0];
        endcase
      end else if (pnd == 8'h60) begin
        if (i_dq[7:0] == 8'h01) lk[b] = 1'b1;
        if (i_dq[7:0] == 8'hD0) lk.delete(b);
        md = (i_dq[7:0] == 8'h04) ? 0 : 1;
        pnd = 8'h00;
      end else begin
        if (pnd != 8'hC0) md = 1;
        if ((pnd == 8'h20 || pnd == 8'hE8) && i_dq[7:0] != 8'hD0) sr[5:4] = 2'b11;
        else if (pnd != 8'hC0 && lk.exists(b)) sr = sr | er;
        else if (pnd != 8'hC0 && !vok) sr = sr | 8'h08;
        else if (pnd != 8'hC0) bsy = int'(i_slow);
        if (pnd != 8'hC0) lop = pnd;
        pnd = 8'h00;
      end
    end
  end
  // ======================================================================
  // status latch, reset and read data
  always @(negedge i_oe_n or negedge i_ce_n) begin
    if (!i_oe_n && !i_ce_n) begin
      lat = (bsy > 0) ? {1'b0, ~sr[6:0]} : sr;
      if (bsy > 0) bsy--;
    end
  end
  always @(negedge i_rpd_n) begin
    sr = 8'h80;
    wa = 1'b0;
    lop = 8'h00;
    md = 0;
    pnd = 8'h00;
    bsy = 0;
  end
  always_comb begin
    case (md)
      0: rv = i_addr[15:0] ^ 16'h5A5A;
      1: rv = {8'h00, lat};
      default: rv = ~i_addr[15:0];
    endcase
  end
  always @(posedge i_oe_n or posedge i_ce_n) lst = rv;
  assign o_dq = (!i_ce_n && !i_oe_n && i_rpd_n) ? rv : ~lst;
endmodule

// File: tb/nfcc_top_tb.sv
// self-checking bench of the flash command controller
// assumes the flash model on the pins and apb driven from the bench
`timescale 1ns/1ns
module nfcc_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic        slow = 1'b0;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        lerr;
  logic        ce_n, oe_n, we_n, rpd_n, dq_oe;
  logic [23:0] fa;
  logic [15:0] dqo, dqi;
  logic        pwe = 1'b1;
  logic [39:0] sq [$];
  logic [15:0] fst [14] = '{16'h00FF, 16'h0070, 16'h0090, 16'h0098, 16'h0040, 16'h00E8,
    16'h0020, 16'h00B0, 16'h0050, 16'h0060, 16'h0060, 16'h00C0, 16'h0060, 16'h0050};
  logic [15:0] snd [14] = '{0, 0, 0, 0, 0, 16'h00D0, 16'h00D0, 0, 16'h00D0, 16'h0001,
    16'h00D0, 0, 16'h0004, 0};
  int          n_fail = 0;
  int          cmp_count = 0;
  int          rlo = 0;
  logic [23:0] ta;
  logic [31:0] q;
  nfcc_top i_nfcc_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_reset_powerdown_n(rpd_n), .o_addr(fa), .o_dq_out(dqo), .o_dq_oe(dq_oe),
    .i_dq_in(dqi));
  nfcc_flash_model i_nfcc_flash_model (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_rpd_n(rpd_n), .i_addr(fa), .i_dq(dqo), .i_slow(slow), .o_dq(dqi));
  // ======================================================================
  // clock and write-cycle monitor
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    pwe <= we_n;
    if (!we_n && pwe && !ce_n && dq_oe) sq.push_back({fa, dqo});
    if (!rpd_n) rlo <= rlo + 1;
  end
  // ======================================================================
  // tasks
  task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    q = prd;
    lerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic run_op(input int op, input logic [23:0] a, input logic [15:0] d);
    int n;
    sq.delete();
    apb(1'b1, 12'h004, {8'h00, a});
    apb(1'b1, 12'h008, {16'h0000, d});
    apb(1'b1, 12'h000, 32'h0000_0100 | 32'(op));
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 200) begin
      apb(1'b0, 12'h00C, 32'h0);
      n++;
    end
    chk("idle", 40'(q[0]), 40'h0);
  endtask
  task automatic seq_op(input int op, input logic [23:0] a, input logic [15:0] d);
    logic [15:0] e [$];
    run_op(op, a, d);
    e = {fst[op]};
    if (op == 4 || op == 11) e.push_back(d);
    else if (snd[op] != 16'h0) e.push_back(snd[op]);
    chk("cycles", 40'(sq.size()), 40'(e.size()));
    foreach (e[i]) begin
      if (i < sq.size()) chk("cycle", sq[i], {a, e[i]});
    end
  endtask
  task automatic sr_rd(input logic [7:0] e);
    run_op(14, ta, 16'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk("devsr", q, {32'h0, e});
    apb(1'b0, 12'h010, 32'h0);
    if (e[7]) chk("rdata", q, {32'h0, e});
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
  // ======================================================================
  // tests
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(31));
    apb(1'b0, 12'h014, 32'h0);
    chk("devsr rst", q, 40'h80);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {lerr, q}, {7'h0, 1'b1, 32'h0});
    $display("reset test done");
    for (int op = 0; op < 14; op++) seq_op(op, 24'($urandom), 16'($urandom));
    $display("code test done");
    ta = 24'($urandom);
    run_op(10, ta, 16'h0);
    run_op(9, ta, 16'h0);
    run_op(4, ta, 16'($urandom));
    apb(1'b0, 12'h00C, 32'h0);
    chk("stat mode", q, 40'h2);
    sr_rd(8'h92);
    sr_rd(8'h92);
    run_op(13, ta, 16'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk("stat clr", q, 40'h2);
    sr_rd(8'h80);
    $display("error test done");
    run_op(10, ta, 16'h0);
    slow <= 1'b1;
    run_op(6, ta, 16'h0);
    slow <= 1'b0;
    sr_rd(8'h00);
    sr_rd(8'h80);
    $display("busy test done");
    run_op(7, ta, 16'h0);
    sr_rd(8'hC0);
    run_op(9, ta, 16'h0);
    run_op(4, ta, 16'($urandom));
    sr_rd(8'hD2);
    run_op(8, ta, 16'h0);
    sr_rd(8'h80);
    $display("suspend test done");
    run_op(0, ta, 16'h0);
    run_op(14, ta, 16'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("array", q, {24'h0, ta[15:0] ^ 16'h5A5A});
    run_op(9, ta, 16'h0);
    run_op(6, ta, 16'h0);
    sr_rd(8'hA2);
    apb(1'b1, 12'h000, 32'h0000_0200);
    repeat (10) @(posedge clk);
    chk("rst low", 40'(rlo), 40'h5);
    run_op(1, ta, 16'h0);
    sr_rd(8'h80);
    $display("flash reset test done");
    close_out();
  end
endmodule
